// [hdl/icc_consts.svh]
// Constants of the IMU calibration signal chain
`ifndef ICC_CONSTS_SVH
`define ICC_CONSTS_SVH
// Register byte offsets
`define ICC_OFS_MISC 8'h00
`define ICC_OFS_FILT 8'h04
`define ICC_OFS_SCALE 8'h08
`define ICC_OFS_STAT 8'h0C
`define ICC_OFS_OUT0 8'h10
`define ICC_OFS_OUTN 8'h24
// Field positions
`define ICC_MISC_POL 0
`define ICC_MISC_SYNC_LSB 2
`define ICC_MISC_SYNC_MSB 4
`define ICC_MISC_POP 6
`define ICC_MISC_LG 7
`define ICC_FILT_LEN_MSB 1
// Reset values
`define ICC_MISC_RST 16'h00C1
`define ICC_FILT_RST 16'h0000
`define ICC_SCALE_RST 16'h0001
// Sync mode codes
`define ICC_SYNC_DIRECT 3'h1
`define ICC_SYNC_SCALED 3'h2
`define ICC_SYNC_PULSE 3'h5
// Bus responses
`define ICC_RESP_OKAY 2'h0
`define ICC_RESP_SLVERR 2'h2
// Timing
`define ICC_CLK_HZ 25000000
`define ICC_PROC_HZ 2000
`define ICC_GADC_HZ 4100
`define ICC_STDR_US 256
`define ICC_PROC_CYC (`ICC_CLK_HZ / `ICC_PROC_HZ)
`define ICC_GADC_CYC (`ICC_CLK_HZ / `ICC_GADC_HZ)
`define ICC_STDR_CYC (`ICC_STDR_US * (`ICC_CLK_HZ / 1000000))
// Arithmetic and sizes
`define ICC_COEF_FRAC 14
`define ICC_UNITY 16'h4000
`define ICC_BIAS_BASE 6'h24
`define ICC_HIST 8
`define ICC_CNT_W 24
`endif

// [hdl/icc_pkg.sv]
// Types of the IMU calibration signal chain
`include "icc_consts.svh"
package icc_pkg;
	typedef logic signed [15:0] icc_smp_t;
	typedef enum logic [1:0] {ICC_INIT, ICC_IDLE, ICC_MAC, ICC_FILT} icc_phase_t;
	typedef struct packed {
		icc_phase_t phase;
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic bvalid;
		logic [1:0] bresp;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [15:0] misc;
		logic [15:0] filt;
		logic [15:0] scale;
		logic [15:0] count;
		logic init_done;
		logic [`ICC_CNT_W-1:0] rate_cnt;
		logic [`ICC_CNT_W-1:0] gsc_cnt;
		logic [`ICC_CNT_W-1:0] dly_cnt;
		logic [`ICC_CNT_W-1:0] per_cnt;
		logic [`ICC_CNT_W-1:0] per_last;
		logic [`ICC_CNT_W:0] frac;
		logic dly_act;
		logic sync_q;
		logic gclk;
		logic rdy;
		icc_smp_t [2:0] glatest;
		icc_smp_t [2:0] gsnap;
		icc_smp_t [2:0] asnap;
		icc_smp_t [5:0] bias;
		icc_smp_t [5:0] corr;
		icc_smp_t [5:0] outv;
		icc_smp_t [5:0][`ICC_HIST-1:0] h1;
		icc_smp_t [5:0][`ICC_HIST-1:0] h2;
		logic [5:0] faddr;
		logic [2:0] iss_o;
		logic [2:0] iss_j;
		logic [2:0] tag_o;
		logic [2:0] tag_j;
		logic tagv;
		logic signed [39:0] acc;
	} icc_state_t;
endpackage

// [hdl/icc_coef_flash.sv]
// Read-only factory coefficient store with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "icc_consts.svh"
module icc_coef_flash #(
	parameter int ADDR_W = 6
) (
	// Clock
	input wire logic clk_i,
	// Read port
	input wire logic [ADDR_W-1:0] addr_i,
	output logic signed [15:0] data_o
);
	logic signed [15:0] data_q;
	logic signed [15:0] data_d;

	// Factory image: unity scale on the diagonals, zero bias and cross terms
	function automatic logic signed [15:0] icc_rom(input logic [ADDR_W-1:0] a);
		int o;
		int j;
		o = int'(a) / 6;
		j = int'(a) % 6;
		if (o < 6 && j < 3 && j == o % 3)
			return `ICC_UNITY;
		return 16'h0000;
	endfunction

	// Table lookup
	always_comb
	begin
		data_d = icc_rom(addr_i);
	end

	// Registered read data
	always_ff @(posedge clk_i)
	begin
		data_q <= data_d;
	end

	assign data_o = data_q;
endmodule
`default_nettype wire

// [hdl/icc_chain.sv]
// IMU calibration signal chain with factory correction and Bartlett filter
// Notes on behaviour
// - Self-initialise, then run continuously at defaults
// - Internal clock default gives 2000 SPS updates
// - Gyro ADC clock ~4100 Hz, processed 2000 Hz
// - Three external sync modes, misc bits 4:2
// - Gyro: matrix times biased rate plus linear-g
// - Accel: matrix, bias, plus percussion times rate squared
// - Misc bit 7 gates linear-g term
// - Misc bit 6 gates percussion term
// - Factory coefficients unreachable from the bus
// - Bartlett filter as two cascaded averagers
// - Direct 001, pulse 101; ready 256 us later
// - Code 010 selects scaled sync mode
`timescale 1ns/10ps
`default_nettype none
`include "icc_consts.svh"
module icc_chain #(
	parameter int PROC_CYC = `ICC_PROC_CYC,
	parameter int GADC_CYC = `ICC_GADC_CYC,
	parameter int STDR_CYC = `ICC_STDR_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// AXI4-Lite write channels
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read channels
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Sensor converters
	input wire icc_pkg::icc_smp_t [2:0] gyro_raw_i,
	input wire icc_pkg::icc_smp_t [2:0] accel_raw_i,
	output logic gyro_adc_sample_clock_o,
	// Sync and data ready
	input wire logic sync_i,
	output logic sample_ready_output_o
);
	import icc_pkg::*;

	icc_state_t q;
	icc_state_t d;
	icc_smp_t coef;

	// Saturate a wide result into a sample
	function automatic icc_smp_t icc_sat(input logic signed [39:0] v);
		if (v > 40'sh0000007FFF)
			return 16'sh7FFF;
		if (v < -40'sh0000008000)
			return icc_smp_t'(16'h8000);
		return v[15:0];
	endfunction

	// Average of the newest 2^n history entries
	function automatic icc_smp_t icc_avg(input icc_smp_t [`ICC_HIST-1:0] h, input logic [1:0] n);
		logic signed [18:0] s;
		s = '0;
		for (int i = 0; i < `ICC_HIST; i++)
		begin
			if (i < (1 << n))
				s = s + 19'(h[i]);
		end
		return icc_smp_t'(s >>> n);
	endfunction

	// Byte-lane merge into a 16-bit register
	function automatic logic [15:0] icc_wmask(input logic [15:0] old, input logic [31:0] w, input logic [3:0] s);
		return {s[1] ? w[15:8] : old[15:8], s[0] ? w[7:0] : old[7:0]};
	endfunction

	// Address lies on the register map
	function automatic logic icc_mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= `ICC_OFS_OUTN);
	endfunction

	icc_coef_flash #(
		.ADDR_W(6)
	) icc_coef_flash_inst (
		.clk_i(clk_i),
		.addr_i(d.faddr),
		.data_o(coef)
	);

	// Next-state logic
	always_comb
	begin
		logic tick;
		logic pulse;
		logic sedge;
		logic [2:0] mode;
		logic [1:0] jj;
		logic [1:0] n;
		logic [7:0] ro;
		logic signed [17:0] opnd;
		logic signed [33:0] prod;
		logic signed [39:0] sum;
		logic signed [31:0] sq;
		icc_smp_t [2:0] gsq;
		tick = 1'b0;
		pulse = 1'b0;
		sedge = sync_i & ~q.sync_q;
		mode = q.misc[`ICC_MISC_SYNC_MSB:`ICC_MISC_SYNC_LSB];
		jj = q.tag_j[1:0] - 2'h3 + ((q.tag_j < 3'h3) ? 2'h3 : 2'h0);
		n = q.filt[`ICC_FILT_LEN_MSB:0];
		ro = s_axi_araddr_i - `ICC_OFS_OUT0;
		opnd = '0;
		prod = '0;
		sum = '0;
		sq = '0;
		gsq = '0;
		d = q;
		d.gclk = 1'b0;
		d.tagv = 1'b0;
		d.sync_q = sync_i;

		if (q.gsc_cnt == '0)
		begin
			d.gsc_cnt = `ICC_CNT_W'(GADC_CYC - 1);
			d.gclk = 1'b1;
		end
		else
			d.gsc_cnt = q.gsc_cnt - 1'b1;
		if (q.gclk)
			d.glatest = gyro_raw_i;

		if (mode == `ICC_SYNC_DIRECT || mode == `ICC_SYNC_PULSE)
		begin
			if (sedge)
			begin
				d.dly_act = 1'b1;
				d.dly_cnt = `ICC_CNT_W'(STDR_CYC - 1);
			end
			else if (q.dly_act)
			begin
				if (q.dly_cnt == '0)
				begin
					tick = 1'b1;
					d.dly_act = 1'b0;
				end
				else
					d.dly_cnt = q.dly_cnt - 1'b1;
			end
		end
		else if (mode == `ICC_SYNC_SCALED)
		begin
			if (q.per_cnt != '1)
				d.per_cnt = q.per_cnt + 1'b1;
			if (sedge)
			begin
				d.per_last = q.per_cnt + 1'b1;
				d.per_cnt = '0;
			end
			if (q.per_last != '0)
			begin
				if (q.frac + {9'h000, q.scale} >= {1'b0, q.per_last})
				begin
					d.frac = q.frac + {9'h000, q.scale} - {1'b0, q.per_last};
					tick = 1'b1;
				end
				else
					d.frac = q.frac + {9'h000, q.scale};
			end
		end
		else
		begin
			if (q.rate_cnt == '0)
			begin
				d.rate_cnt = `ICC_CNT_W'(PROC_CYC - 1);
				tick = 1'b1;
			end
			else
				d.rate_cnt = q.rate_cnt - 1'b1;
		end

		// Squares of corrected rates
		for (int k = 0; k < 3; k++)
		begin
			sq = q.corr[k] * q.corr[k];
			gsq[k] = sq[31:16];
		end

		// Processing sequence
		unique case (q.phase)
			ICC_INIT:
			begin
				if (q.tagv)
					d.bias[q.tag_j] = coef;
				if (q.iss_j != 3'h6)
				begin
					d.faddr = `ICC_BIAS_BASE + {3'h0, q.iss_j};
					d.tagv = 1'b1;
					d.tag_j = q.iss_j;
					d.iss_j = q.iss_j + 3'h1;
				end
				else if (!q.tagv)
				begin
					d.phase = ICC_IDLE;
					d.init_done = 1'b1;
					d.iss_j = 3'h0;
				end
			end
			ICC_IDLE:
			begin
				if (tick)
				begin
					d.gsnap = q.glatest;
					d.asnap = accel_raw_i;
					d.iss_o = 3'h0;
					d.iss_j = 3'h0;
					d.phase = ICC_MAC;
				end
			end
			ICC_MAC:
			begin
				if (q.iss_o != 3'h6)
				begin
					d.faddr = 6'({3'h0, q.iss_o} * 6'h06 + {3'h0, q.iss_j});
					d.tagv = 1'b1;
					d.tag_o = q.iss_o;
					d.tag_j = q.iss_j;
					if (q.iss_j == 3'h5)
					begin
						d.iss_j = 3'h0;
						d.iss_o = q.iss_o + 3'h1;
					end
					else
						d.iss_j = q.iss_j + 3'h1;
				end
				if (q.tagv)
				begin
					if (q.tag_o < 3'h3)
					begin
						if (q.tag_j < 3'h3)
							opnd = 18'(q.gsnap[jj]) + 18'(q.bias[jj]);
						else if (q.misc[`ICC_MISC_LG])
							opnd = 18'(q.corr[q.tag_j]);
					end
					else
					begin
						if (q.tag_j < 3'h3)
							opnd = 18'(q.asnap[jj]);
						else if (q.misc[`ICC_MISC_POP] && q.tag_j != q.tag_o)
							opnd = 18'(gsq[jj]);
					end
					prod = coef * opnd;
					sum = ((q.tag_j == 3'h0) ? 40'sh0000000000 : q.acc) + 40'(prod);
					d.acc = sum;
					if (q.tag_j == 3'h5)
					begin
						if (q.tag_o >= 3'h3)
							sum = sum + (40'(q.bias[q.tag_o]) <<< `ICC_COEF_FRAC);
						d.corr[q.tag_o] = icc_sat(sum >>> `ICC_COEF_FRAC);
						if (q.tag_o == 3'h5)
							d.phase = ICC_FILT;
					end
				end
			end
			ICC_FILT:
			begin
				for (int c = 0; c < 6; c++)
				begin
					d.h1[c] = {q.h1[c][`ICC_HIST-2:0], q.corr[c]};
					d.h2[c] = {q.h2[c][`ICC_HIST-2:0], icc_avg(d.h1[c], n)};
					d.outv[c] = icc_avg(d.h2[c], n);
				end
				d.count = q.count + 16'h0001;
				pulse = 1'b1;
				d.phase = ICC_IDLE;
			end
		endcase
		d.rdy = pulse ? q.misc[`ICC_MISC_POL] : ~q.misc[`ICC_MISC_POL];

		// Write address and data capture
		if (s_axi_awvalid_i && q.awready)
		begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && q.wready)
		begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata_i;
			d.wstrb = s_axi_wstrb_i;
		end
		if (q.bvalid && s_axi_bready_i)
			d.bvalid = 1'b0;
		// Register write once both halves are in
		if (q.aw_got && q.w_got && !q.bvalid)
		begin
			if (q.awaddr == `ICC_OFS_MISC)
				d.misc = icc_wmask(q.misc, q.wdata, q.wstrb);
			else if (q.awaddr == `ICC_OFS_FILT)
				d.filt = icc_wmask(q.filt, q.wdata, q.wstrb);
			else if (q.awaddr == `ICC_OFS_SCALE)
				d.scale = icc_wmask(q.scale, q.wdata, q.wstrb);
			d.bresp = icc_mapped(q.awaddr) ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
			d.bvalid = 1'b1;
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
		end
		d.awready = ~d.aw_got & ~d.bvalid;
		d.wready = ~d.w_got & ~d.bvalid;

		// Register read
		if (q.rvalid && s_axi_rready_i)
			d.rvalid = 1'b0;
		if (s_axi_arvalid_i && q.arready)
		begin
			d.rvalid = 1'b1;
			d.rresp = icc_mapped(s_axi_araddr_i) ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
			d.rdata = 32'h00000000;
			if (!icc_mapped(s_axi_araddr_i))
				d.rdata = 32'h00000000;
			else if (s_axi_araddr_i == `ICC_OFS_MISC)
				d.rdata = {16'h0000, q.misc};
			else if (s_axi_araddr_i == `ICC_OFS_FILT)
				d.rdata = {16'h0000, q.filt};
			else if (s_axi_araddr_i == `ICC_OFS_SCALE)
				d.rdata = {16'h0000, q.scale};
			else if (s_axi_araddr_i == `ICC_OFS_STAT)
				d.rdata = {q.count, 15'h0000, q.init_done};
			else
				d.rdata = {16'h0000, q.outv[ro[4:2]]};
		end
		d.arready = ~d.rvalid;
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			q <= '0;
			q.phase <= ICC_INIT;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
			q.misc <= `ICC_MISC_RST;
			q.filt <= `ICC_FILT_RST;
			q.scale <= `ICC_SCALE_RST;
		end
		else
			q <= d;
	end

	// Outputs from the state register
	assign s_axi_awready_o = q.awready;
	assign s_axi_wready_o = q.wready;
	assign s_axi_bresp_o = q.bresp;
	assign s_axi_bvalid_o = q.bvalid;
	assign s_axi_arready_o = q.arready;
	assign s_axi_rdata_o = q.rdata;
	assign s_axi_rresp_o = q.rresp;
	assign s_axi_rvalid_o = q.rvalid;
	assign gyro_adc_sample_clock_o = q.gclk;
	assign sample_ready_output_o = q.rdy;
endmodule
`default_nettype wire

// [testbench/icc_chain_monitor.sv]
// Port checker of the calibration chain
`timescale 1ns/10ps
`default_nettype none
module icc_chain_monitor #(
	parameter int PROC_CYC = 200,
	parameter int GADC_CYC = 50,
	parameter int STDR_CYC = 20
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Register bus
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Sensor side
	input wire logic gyro_adc_sample_clock_o,
	input wire logic sync_i,
	input wire logic sample_ready_output_o
);
	localparam int RDY_LO = STDR_CYC;
	localparam int RDY_HI = STDR_CYC + 70;
	logic [2:0] mode_q;
	logic rseen_q, gseen_q;
	logic [23:0] rgap_q, ggap_q;
	// Snoop the sync mode and time the gaps between pulses
	always_ff @(posedge clk_i)
	begin
		rgap_q <= sample_ready_output_o ? 24'h0 : rgap_q + 24'h1;
		ggap_q <= gyro_adc_sample_clock_o ? 24'h0 : ggap_q + 24'h1;
		gseen_q <= !reset_i && (gseen_q || gyro_adc_sample_clock_o);
		if (reset_i)
			mode_q <= 3'h0;
		else if (s_axi_awvalid_i && s_axi_awready_o && s_axi_awaddr_i == 8'h00)
			mode_q <= s_axi_wdata_i[4:2];
		if (reset_i || (s_axi_awvalid_i && s_axi_awready_o && s_axi_awaddr_i == 8'h00))
			rseen_q <= 1'h0;
		else if (sample_ready_output_o)
			rseen_q <= 1'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Timing of the sample clocks, ready pulse and bus answers
	a_int_rate: assert property (sample_ready_output_o && rseen_q && mode_q == 3'h0 |-> rgap_q == PROC_CYC - 1)
		else $error("ready spacing wrong");
	a_gclk_period: assert property (gyro_adc_sample_clock_o && gseen_q |-> ggap_q == GADC_CYC - 1)
		else $error("gyro clock period wrong");
	a_gclk_pulse: assert property (gyro_adc_sample_clock_o |=> !gyro_adc_sample_clock_o)
		else $error("gyro clock too long");
	a_rdy_pulse: assert property (sample_ready_output_o |=> !sample_ready_output_o)
		else $error("ready too long");
	a_sync_delay: assert property ($rose(sync_i) && (mode_q == 3'h1 || mode_q == 3'h5)
		|-> ##[RDY_LO:RDY_HI] sample_ready_output_o)
		else $error("no ready after sync");
	a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read not answered");
	a_rd_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rresp_o))
		else $error("read answer dropped");
	a_wr_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write answer dropped");
	c_int: cover property (sample_ready_output_o && rseen_q && mode_q == 3'h0);
	c_direct: cover property (sample_ready_output_o && mode_q == 3'h1);
	c_scaled: cover property (sample_ready_output_o && mode_q == 3'h2);
endmodule
bind icc_chain icc_chain_monitor #(.PROC_CYC(PROC_CYC), .GADC_CYC(GADC_CYC), .STDR_CYC(STDR_CYC))
	icc_chain_monitor_inst (.clk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rresp_o,
		.s_axi_rvalid_o, .s_axi_rready_i, .gyro_adc_sample_clock_o, .sync_i, .sample_ready_output_o);
`default_nettype wire

// [testbench/icc_adc_model.sv]
// Sensor converter model feeding raw gyro and accel words
`timescale 1ns/10ps
`default_nettype none
module icc_adc_model (
	// Clocks
	input wire logic clk_i,
	input wire logic gyro_adc_sample_clock_i,
	// New readings from the bench
	input wire logic load_i,
	input wire icc_pkg::icc_smp_t [5:0] value_i,
	// Converter outputs
	output var icc_pkg::icc_smp_t [2:0] gyro_raw_o,
	output var icc_pkg::icc_smp_t [2:0] accel_raw_o
);
	import icc_pkg::*;
	icc_smp_t [5:0] pend_q;
	// gyro word refreshes only on its own converter clock
	always_ff @(posedge clk_i)
	begin
		if (load_i)
			pend_q <= value_i;
		if (gyro_adc_sample_clock_i)
			gyro_raw_o <= pend_q[2:0];
		accel_raw_o <= pend_q[5:3];
	end
endmodule
`default_nettype wire

// [testbench/test_imu_calibration_signal_chain.sv]
// Bench of the calibration chain
`timescale 1ns/10ps
`default_nettype none
`include "icc_consts.svh"
module test_imu_calibration_signal_chain;
	import icc_pkg::*;
	logic clk_i = 1'h0, reset_i = 1'h1, sync_i = 1'h0, load = 1'h1, aw, wr, ar, done;
	logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0, s_axi_arvalid_i = 1'h0;
	logic s_axi_rready_i = 1'h0, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic s_axi_rvalid_o, gyro_adc_sample_clock_o, sample_ready_output_o;
	logic [7:0] s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
	logic [3:0] s_axi_wstrb_i = 4'hF;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
	icc_smp_t [2:0] gyro_raw_i, accel_raw_i;
	icc_smp_t [5:0] vals = '0;
	int miscompares = 0, tests_run = 0, seed = 85586, n, f, k;
	logic [7:0] bad [3] = '{8'h28, 8'h02, 8'h40};
	logic [2:0] codes [2] = '{3'h1, 3'h5};
	// Clock and parts under test
	always #20 clk_i = ~clk_i;
	icc_chain #(.PROC_CYC(200), .GADC_CYC(50), .STDR_CYC(20)) icc_chain_inst (.clk_i, .reset_i, .s_axi_awaddr_i,
		.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
		.s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .gyro_raw_i, .accel_raw_i,
		.gyro_adc_sample_clock_o, .sync_i, .sample_ready_output_o);
	icc_adc_model icc_adc_model_inst (.clk_i, .gyro_adc_sample_clock_i(gyro_adc_sample_clock_o), .load_i(load),
		.value_i(vals), .gyro_raw_o(gyro_raw_i), .accel_raw_o(accel_raw_i));
	// Comparison, verdict and bench helpers
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic hang();
		check("wait", 32'h1, 32'h0);
		give_verdict();
	endtask
	function automatic logic [31:0] exp_out(input int j);
		return {16'h0, vals[j]};
	endfunction
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_araddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= w;
		s_axi_wvalid_i <= w;
		s_axi_arvalid_i <= !w;
		s_axi_bready_i <= w;
		s_axi_rready_i <= !w;
		for (k = 0; k < 60; k++)
		begin
			@(negedge clk_i);
			done = w ? s_axi_bvalid_o : s_axi_rvalid_o;
			rsp = w ? s_axi_bresp_o : s_axi_rresp_o;
			rd = s_axi_rdata_o;
			aw = s_axi_awready_o;
			wr = s_axi_wready_o;
			ar = s_axi_arready_o;
			@(posedge clk_i);
			if (aw === 1'h1)
				s_axi_awvalid_i <= 1'h0;
			if (wr === 1'h1)
				s_axi_wvalid_i <= 1'h0;
			if (ar === 1'h1)
				s_axi_arvalid_i <= 1'h0;
			if (done === 1'h1)
				break;
		end
		s_axi_bready_i <= 1'h0;
		s_axi_rready_i <= 1'h0;
		if (k == 60)
			hang();
	endtask
	task automatic wait_rdy(input int lim, input logic must);
		for (n = 0; n < lim; n++)
		begin
			@(negedge clk_i);
			if (sample_ready_output_o === 1'h1)
				break;
		end
		if (must && n == lim)
			hang();
	endtask
	task automatic sync_burst();
		@(posedge clk_i);
		sync_i <= 1'h1;
		n = 0;
		f = -1;
		for (k = 0; k < 12000; k++)
		begin
			@(negedge clk_i);
			if (sample_ready_output_o === 1'h1)
				n++;
			if (sample_ready_output_o === 1'h1 && f < 0)
				f = k;
			@(posedge clk_i);
			// pulse held over 5 us, next rise 480 us on
			if (k == 130)
				sync_i <= 1'h0;
		end
	endtask
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'h0;
		load <= 1'h0;
		wait_rdy(400, 1'h1);
		xfer(1'h0, `ICC_OFS_MISC, 32'h0);
		check("misc reset", rd, 32'hC1);
		xfer(1'h0, `ICC_OFS_FILT, 32'h0);
		check("filter reset", rd, 32'h0);
		xfer(1'h0, `ICC_OFS_STAT, 32'h0);
		check("init done", rd[0], 1'h1);
		wait_rdy(400, 1'h1);
		wait_rdy(400, 1'h1);
		check("internal period", n + 1, 32'hC8);
		// Sample count steps once per update
		xfer(1'h0, `ICC_OFS_STAT, 32'h0);
		f = rd[31:16];
		wait_rdy(400, 1'h1);
		xfer(1'h0, `ICC_OFS_STAT, 32'h0);
		check("sample count", rd[31:16] - f[15:0], 32'h1);
		foreach (bad[i])
		begin
			xfer(1'h0, bad[i], 32'h0);
			check("refused read", rsp, `ICC_RESP_SLVERR);
			check("refused data", rd, 32'h0);
		end
		xfer(1'h1, 8'h28, 32'h1);
		check("refused write", rsp, `ICC_RESP_SLVERR);
		for (int c = 0; c < 4; c++)
		begin
			if (c == 2)
				xfer(1'h1, `ICC_OFS_MISC, 32'h1);
			if (c == 3)
				xfer(1'h1, `ICC_OFS_FILT, 32'h1);
			@(posedge clk_i);
			vals <= c == 0 ? {16'h8000, 16'h7FFF, 16'h8000, 16'h7FFF, 16'hFFFF, 16'h0001} :
				{$random(seed), $random(seed), $random(seed)};
			load <= 1'h1;
			@(posedge clk_i);
			load <= 1'h0;
			repeat (c == 3 ? 8 : 3) wait_rdy(400, 1'h1);
			if (c == 1)
			begin
				xfer(1'h1, `ICC_OFS_OUT0, 32'h1234);
				check("read-only write", rsp, `ICC_RESP_OKAY);
			end
			for (int j = 0; j < 6; j++)
			begin
				xfer(1'h0, `ICC_OFS_OUT0 + 8'(4 * j), 32'h0);
				check("output", rd, exp_out(j));
			end
		end
		xfer(1'h0, `ICC_OFS_FILT, 32'h0);
		check("filter setting", rd, 32'h1);
		foreach (codes[i])
		begin
			xfer(1'h1, `ICC_OFS_MISC, {24'h0, 2'h3, 1'h0, codes[i], 1'h0, 1'h1});
			wait_rdy(100, 1'h0);
			wait_rdy(1000, 1'h0);
			check("no tick without sync", n, 32'h3E8);
			sync_burst();
			check("ready per sync", n, 32'h1);
			check("sync to ready", f >= 20 && f <= 90, 1'h1);
		end
		xfer(1'h1, `ICC_OFS_SCALE, 32'h2);
		xfer(1'h1, `ICC_OFS_MISC, 32'hC9);
		repeat (3) sync_burst();
		check("scaled ticks", n, 32'h2);
		give_verdict();
	end
endmodule
`default_nettype wire
